// ==== bmsd_pkg.sv ====
`default_nettype none
package bmsd_pkg;
  // Clock rate and access figures.
  localparam int CLK_MHZ = 20;
  localparam int FLASH_WAIT = 3;
  localparam int SRAM_FIRST = 3;
  localparam int SRAM_NEXT = 1;
  localparam int DRAM_FIRST = 3;
  localparam int DRAM_NEXT = 2;
  localparam int BURST_BEATS = 4;
  // Refresh interval in nanoseconds and its cycle count.
  localparam int REFRESH_NS = 15600;
  localparam int REFRESH_CYC = (REFRESH_NS * CLK_MHZ) / 1000;
  localparam int REFRESH_LEN = 3;
  // Region codes decoded from the address.
  localparam logic [2:0] REG_NONE = 3'h0;
  localparam logic [2:0] REG_FLASH = 3'h1;
  localparam logic [2:0] REG_SRAM = 3'h2;
  localparam logic [2:0] REG_DRAM = 3'h3;
  localparam logic [2:0] REG_BFLASH = 3'h4;
  // Presence-detect field positions.
  localparam int PD_TIME_LSB = 2;
  localparam int PD_ORG_LSB = 0;
  localparam int PD_TWO_BANK_BIT = 0;
  // Access times in ns, indexed by the time field.
  localparam logic [7:0] TIME_NS_0 = 8'h64;
  localparam logic [7:0] TIME_NS_1 = 8'h50;
  localparam logic [7:0] TIME_NS_2 = 8'h46;
  localparam logic [7:0] TIME_NS_3 = 8'h3c;
  // Module depth in 256K-word units, indexed by the organisation field.
  localparam logic [3:0] ORG_UNITS_0 = 4'h4;
  localparam logic [3:0] ORG_UNITS_1 = 4'h2;
  localparam logic [3:0] ORG_UNITS_2 = 4'h1;
  localparam logic [3:0] ORG_UNITS_3 = 4'h8;
endpackage
`default_nettype wire

// ==== bmsd_pd_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module bmsd_pd_decode (
  // Presence-detect code, already synchronised.
  input wire logic [3:0] pd_code,
  // Decoded module properties.
  output logic [7:0] access_ns,
  output logic [3:0] size_units,
  output logic two_banks
);
  logic [1:0] time_sel;
  logic [1:0] org_sel;
  assign time_sel = pd_code[bmsd_pkg::PD_TIME_LSB +: 2];
  assign org_sel = pd_code[bmsd_pkg::PD_ORG_LSB +: 2];
  always_comb begin
    unique case (time_sel)
      2'h0: access_ns = bmsd_pkg::TIME_NS_0;
      2'h1: access_ns = bmsd_pkg::TIME_NS_1;
      2'h2: access_ns = bmsd_pkg::TIME_NS_2;
      2'h3: access_ns = bmsd_pkg::TIME_NS_3;
    endcase
    unique case (org_sel)
      2'h0: size_units = bmsd_pkg::ORG_UNITS_0;
      2'h1: size_units = bmsd_pkg::ORG_UNITS_1;
      2'h2: size_units = bmsd_pkg::ORG_UNITS_2;
      2'h3: size_units = bmsd_pkg::ORG_UNITS_3;
    endcase
  end
  assign two_banks = pd_code[bmsd_pkg::PD_TWO_BANK_BIT];
endmodule
`default_nettype wire

// ==== bmsd_ctrl.sv ====
// What this block does
// - Doubled clock follows oscillator until lock.
// - Flash acknowledged after three wait states.
// - Boot chip select selects flash.
// - Burst SRAM timing 3,1,1,1 or 3.
// - DRAM timing 3,2,2,2 or 3.
// - DRAM single, burst and refresh control.
// - DRAM reachable from core and DMA.
// - DMA uses single DRAM accesses only.
// - Address multiplexing done outside the controller.
// - Upper code bits select access time.
// - Lower code bits select organisation.
// - Two-bank modules drive both row strobes.
// - Chip selects for all memories, glueless.
// - Acknowledge core and DMA by timing.
// - DMA may master while CPU disabled.
`timescale 1ns/10ps
`default_nettype none
module bmsd_ctrl #(
  parameter int REFRESH_CYCLES = bmsd_pkg::REFRESH_CYC
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Clock doubling: oscillator in, doubled clock in from the PLL.
  input wire logic oscillator_input,
  input wire logic pll_clock,
  input wire logic pll_locked,
  output logic doubled_clock_output,
  // Access request: start pulse with region, burst and source.
  input wire logic req_start,
  input wire logic [2:0] req_region,
  input wire logic req_burst,
  input wire logic req_from_dma,
  input wire logic dma_master_en,
  // Acknowledges, active low, one cycle per beat; busy is high whenever not idle.
  output logic transfer_acknowledge_b,
  output logic port_size_handshake_b,
  output logic busy,
  // Memory selects and strobes, active low; row_addr_sel high selects the row address.
  output logic boot_chip_select_b,
  output logic burst_boot_select_b,
  output logic burst_static_memory_select_b,
  output logic dram_select_b,
  output logic row_strobe_first_b,
  output logic row_strobe_second_b,
  output logic col_strobe_b,
  output logic row_addr_sel,
  // Presence detect pins and decoded state.
  input wire logic [3:0] presence_detect_code,
  output logic [7:0] dram_access_ns,
  output logic [3:0] dram_size_units,
  output logic dram_two_banks
);
  if (REFRESH_CYCLES < 8 || REFRESH_CYCLES > 65535) begin : g_bad_refresh
    $error("REFRESH_CYCLES out of range");
  end

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_ACK = 4'h4,
    ST_REFRESH = 4'h8
  } bmsd_state_e;

  logic rst_s1_reg, rst_s2_reg, rst_n;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // The lock pin is asynchronous; only the second stage steers the mux.
  logic lock_s1_reg, lock_s2_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_s1_reg <= 1'b0;
      lock_s2_reg <= 1'b0;
    end else begin
      lock_s1_reg <= pll_locked;
      lock_s2_reg <= lock_s1_reg;
    end
  end
  // A plain clock mux; the switch happens once after lock, and a glitch
  // then is accepted as the PLL output itself is settling.
  assign doubled_clock_output = lock_s2_reg ? pll_clock
                                            : oscillator_input;

  logic [3:0] pd_s1_reg, pd_s2_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_s1_reg <= 4'h0;
      pd_s2_reg <= 4'h0;
    end else begin
      pd_s1_reg <= presence_detect_code;
      pd_s2_reg <= pd_s1_reg;
    end
  end

  bmsd_pd_decode u_pd (
    .pd_code(pd_s2_reg),
    .access_ns(dram_access_ns),
    .size_units(dram_size_units),
    .two_banks(dram_two_banks)
  );

  bmsd_state_e state_reg;
  logic [2:0] region_reg;
  logic dma_reg, burst_reg;
  logic [2:0] wait_reg;
  logic [2:0] beat_reg;
  logic [15:0] refresh_cnt_reg;
  logic refresh_pend_reg;
  logic take_req, mapped, burst_ok;

  // Refresh interval counter; refresh waits for the current access.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      refresh_cnt_reg <= 16'h0000;
      refresh_pend_reg <= 1'b0;
    end else if (refresh_cnt_reg == 16'(REFRESH_CYCLES - 1)) begin
      refresh_cnt_reg <= 16'h0000;
      refresh_pend_reg <= 1'b1;
    end else begin
      refresh_cnt_reg <= refresh_cnt_reg + 16'h0001;
      if (state_reg == ST_REFRESH && wait_reg == 3'h0) begin
        refresh_pend_reg <= 1'b0;
      end
    end
  end

  // Spare region codes select nothing, so they must never be answered.
  assign mapped = req_region == bmsd_pkg::REG_FLASH ||
                  req_region == bmsd_pkg::REG_SRAM ||
                  req_region == bmsd_pkg::REG_DRAM ||
                  req_region == bmsd_pkg::REG_BFLASH;
  // DMA is accepted whenever enabled; no CPU state gates it.
  assign take_req = state_reg == ST_IDLE && !refresh_pend_reg &&
                    req_start && mapped &&
                    (!req_from_dma || dma_master_en);
  // Only the core gets bursts; DMA falls back to single accesses.
  assign burst_ok = req_burst && !req_from_dma &&
                    req_region != bmsd_pkg::REG_FLASH;

  function automatic logic [2:0] first_wait(input logic [2:0] r);
    unique case (r)
      bmsd_pkg::REG_FLASH,
      bmsd_pkg::REG_BFLASH: first_wait = 3'(bmsd_pkg::FLASH_WAIT);
      bmsd_pkg::REG_SRAM: first_wait = 3'(bmsd_pkg::SRAM_FIRST - 1);
      default: first_wait = 3'(bmsd_pkg::DRAM_FIRST - 1);
    endcase
  endfunction

  function automatic logic [2:0] next_wait(input logic [2:0] r);
    if (r == bmsd_pkg::REG_SRAM) begin
      next_wait = 3'(bmsd_pkg::SRAM_NEXT - 1);
    end else begin
      next_wait = 3'(bmsd_pkg::DRAM_NEXT - 1);
    end
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      region_reg <= bmsd_pkg::REG_NONE;
      dma_reg <= 1'b0;
      burst_reg <= 1'b0;
      wait_reg <= 3'h0;
      beat_reg <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (refresh_pend_reg) begin
            state_reg <= ST_REFRESH;
            wait_reg <= 3'(bmsd_pkg::REFRESH_LEN - 1);
          end else if (take_req) begin
            region_reg <= req_region;
            dma_reg <= req_from_dma;
            burst_reg <= burst_ok;
            beat_reg <= 3'(bmsd_pkg::BURST_BEATS - 1);
            wait_reg <= first_wait(req_region);
            state_reg <= (first_wait(req_region) == 3'h0) ? ST_ACK
                                                         : ST_WAIT;
          end
        end
        ST_WAIT: begin
          wait_reg <= wait_reg - 3'h1;
          if (wait_reg == 3'h1) begin
            state_reg <= ST_ACK;
          end
        end
        ST_ACK: begin
          if (burst_reg && beat_reg != 3'h0) begin
            beat_reg <= beat_reg - 3'h1;
            wait_reg <= next_wait(region_reg);
            state_reg <= (next_wait(region_reg) == 3'h0) ? ST_ACK
                                                        : ST_WAIT;
          end else begin
            state_reg <= ST_IDLE;
            region_reg <= bmsd_pkg::REG_NONE;
          end
        end
        ST_REFRESH: begin
          wait_reg <= wait_reg - 3'h1;
          if (wait_reg == 3'h0) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  logic ack;
  logic in_access, in_dram;
  assign ack = state_reg == ST_ACK;
  assign in_access = state_reg == ST_WAIT || state_reg == ST_ACK;
  assign in_dram = in_access && region_reg == bmsd_pkg::REG_DRAM;
  assign busy = state_reg != ST_IDLE;

  assign transfer_acknowledge_b = !(ack && !dma_reg);
  assign port_size_handshake_b = !(ack && dma_reg);

  assign boot_chip_select_b = !(in_access &&
                                region_reg == bmsd_pkg::REG_FLASH);
  assign burst_boot_select_b = !(in_access &&
                                 region_reg == bmsd_pkg::REG_BFLASH);
  assign burst_static_memory_select_b = !(in_access &&
                                          region_reg == bmsd_pkg::REG_SRAM);
  assign dram_select_b = !in_dram;

  // Refresh and accesses alike strobe the second bank only on
  // two-bank modules.
  assign row_strobe_first_b = !(in_dram || state_reg == ST_REFRESH);
  assign row_strobe_second_b = !(dram_two_banks &&
                                 (in_dram ||
                                  state_reg == ST_REFRESH));
  assign col_strobe_b = !(in_dram && (wait_reg == 3'h0 || ack) ||
                          state_reg == ST_REFRESH);
  // Row/column select for the external address multiplexers.
  assign row_addr_sel = !(in_dram && wait_reg <= 3'h1);

  a_one_ack_beat: assert property (@(posedge core_clk) disable iff (!rst_n)
    ack && !burst_reg |=> !ack)
    else $error("single access acknowledged twice");
  a_flash_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
    take_req && req_region == bmsd_pkg::REG_FLASH |=> !ack [*3] ##1 ack)
    else $error("flash wait states wrong");
  a_sram_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    take_req && req_region == bmsd_pkg::REG_SRAM && !burst_ok
    |=> !ack ##1 !ack ##1 ack)
    else $error("sram single access not three cycles");
  a_sram_burst: assert property (@(posedge core_clk) disable iff (!rst_n)
    take_req && req_region == bmsd_pkg::REG_SRAM && burst_ok
    |=> !ack [*2] ##1 ack [*4] ##1 !ack)
    else $error("sram burst not 3,1,1,1");
  a_dram_burst: assert property (@(posedge core_clk) disable iff (!rst_n)
    take_req && req_region == bmsd_pkg::REG_DRAM && burst_ok
    |=> !ack [*2] ##1 ack ##1 !ack ##1 ack ##1 !ack ##1 ack ##1 !ack
        ##1 ack)
    else $error("dram burst not 3,2,2,2");
  a_dma_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    ack && dma_reg |-> !burst_reg && transfer_acknowledge_b)
    else $error("dma access bursting or acked to core");
  a_unmapped_none: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_reg == ST_IDLE && req_start && !mapped |=> !in_access)
    else $error("unmapped access acknowledged");
  a_two_bank: assert property (@(posedge core_clk) disable iff (!rst_n)
    !row_strobe_second_b |-> dram_two_banks && !row_strobe_first_b)
    else $error("second row strobe on single-bank module");
  a_refresh_len: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state_reg == ST_REFRESH) |-> !row_strobe_first_b [*3]
    ##1 row_strobe_first_b)
    else $error("refresh length wrong");
endmodule
`default_nettype wire

// ==== bmsd_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module bmsd_master_model (
  // Clock and command from the bench.
  input wire logic core_clk,
  input wire logic go,
  input wire logic [2:0] cmd_region,
  input wire logic cmd_burst,
  input wire logic cmd_dma,
  // Request towards the block.
  output logic req_start,
  output logic [2:0] req_region,
  output logic req_burst,
  output logic req_from_dma,
  // Answer from the block.
  input wire logic busy,
  input wire logic tack_b,
  input wire logic hsk_b,
  input wire logic [3:0] sel_b,
  input wire logic row2_b,
  // What was seen for the current command.
  output logic taken,
  output logic done,
  output int n_ack,
  output int n_wrong,
  output logic [3:0][7:0] stamp,
  output logic [3:0] sel_seen,
  output logic row2_seen
);
  int age;
  logic ack_now, ack_bad;
  assign ack_now = cmd_dma ? !hsk_b : !tack_b;
  assign ack_bad = cmd_dma ? !tack_b : !hsk_b;
  initial begin
    req_start = 1'b0;
    req_region = 3'h0;
    req_burst = 1'b0;
    req_from_dma = 1'b0;
  end
  // A select going low is the only sign of a take, since a pending refresh
  // may hold the request off while busy is already high.
  always @(posedge core_clk) begin
    req_start <= go && !taken;
    if (go && !taken) begin
      // The region comes already decoded, so the register block base never
      // reaches this block; flash is only ever read, never programmed.
      req_region <= cmd_region;
      req_burst <= cmd_burst;
      req_from_dma <= cmd_dma;
    end else begin
      // Released qualifiers keep moving so no stale value can be relied on.
      req_region <= ~req_region;
      req_burst <= ~req_burst;
      req_from_dma <= ~req_from_dma;
    end
    if (!go) begin
      taken <= 1'b0;
      done <= 1'b0;
      n_ack <= 0;
      n_wrong <= 0;
      age <= 0;
      sel_seen <= 4'h0;
      row2_seen <= 1'b0;
    end else begin
      if (sel_b != 4'hf) taken <= 1'b1;
      sel_seen <= sel_seen | ~sel_b;
      if (taken || sel_b != 4'hf) age <= age + 1;
      if (ack_now && n_ack < 4) stamp[n_ack] <= 8'(age);
      if (ack_now) n_ack <= n_ack + 1;
      if (ack_bad) n_wrong <= n_wrong + 1;
      if (!row2_b) row2_seen <= 1'b1;
      done <= taken && sel_b == 4'hf && !busy;
    end
  end
endmodule
`default_nettype wire

// ==== board_memory_select_and_dram_control_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module board_memory_select_and_dram_control_tb;
  logic core_clk, rst_b, osc, pll_clk, pll_locked, dma_en, go, two;
  logic cmd_burst, cmd_dma, req_start, req_burst, req_from_dma, dco, busy;
  logic tack_b, hsk_b, boot_b, bboot_b, sram_b, dram_b, row1_b, row2_b;
  logic cas_b, row_sel, taken, done, row2_seen;
  logic [2:0] cmd_region, req_region;
  logic [3:0] pd, units, sel_seen;
  logic [7:0] acc_ns;
  int n_ack, n_wrong, fails, checks;
  logic [3:0][7:0] stamp;
  bmsd_ctrl #(.REFRESH_CYCLES(40)) u_dut (
    .core_clk(core_clk), .rst_b(rst_b), .oscillator_input(osc),
    .pll_clock(pll_clk), .pll_locked(pll_locked),
    .doubled_clock_output(dco), .req_start(req_start),
    .req_region(req_region), .req_burst(req_burst),
    .req_from_dma(req_from_dma), .dma_master_en(dma_en),
    .transfer_acknowledge_b(tack_b), .port_size_handshake_b(hsk_b),
    .busy(busy), .boot_chip_select_b(boot_b), .burst_boot_select_b(bboot_b),
    .burst_static_memory_select_b(sram_b), .dram_select_b(dram_b),
    .row_strobe_first_b(row1_b), .row_strobe_second_b(row2_b),
    .col_strobe_b(cas_b), .row_addr_sel(row_sel),
    .presence_detect_code(pd),
    .dram_access_ns(acc_ns), .dram_size_units(units), .dram_two_banks(two));
  bmsd_master_model u_model (
    .core_clk(core_clk), .go(go), .cmd_region(cmd_region),
    .cmd_burst(cmd_burst), .cmd_dma(cmd_dma), .req_start(req_start),
    .req_region(req_region), .req_burst(req_burst),
    .req_from_dma(req_from_dma), .busy(busy), .tack_b(tack_b),
    .hsk_b(hsk_b), .sel_b({dram_b, sram_b, bboot_b, boot_b}),
    .row2_b(row2_b), .taken(taken), .done(done), .n_ack(n_ack),
    .n_wrong(n_wrong), .stamp(stamp), .sel_seen(sel_seen),
    .row2_seen(row2_seen));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // The oscillator is half the PLL clock, so the two are told apart.
  initial begin
    pll_clk = 1'b0;
    forever #10 pll_clk = ~pll_clk;
  end
  always @(posedge pll_clk) osc <= ~osc;
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic close_out;
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run(logic [2:0] r, logic b, logic d);
    int i;
    @(negedge core_clk);
    cmd_region = r;
    cmd_burst = b;
    cmd_dma = d;
    go = 1'b1;
    for (i = 0; i < 200 && done !== 1'b1; i++) @(negedge core_clk);
    if (i == 200) begin
      chk("access done", 1, done);
      close_out();
    end
  endtask
  task automatic stop;
    @(negedge core_clk);
    go = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask
  task automatic access(logic [2:0] r, logic b, logic d, int beats,
                        int first, int gap, logic [3:0] sel);
    run(r, b, d);
    chk("ack count", beats, n_ack);
    chk("wrong ack", 0, n_wrong);
    chk("select", sel, sel_seen);
    for (int k = 0; k < beats; k++) begin
      chk("beat time", first + k * gap, stamp[k]);
    end
    stop();
  endtask
  task automatic t_lock;
    pll_locked = 1'b1;
    repeat (4) @(negedge core_clk);
    repeat (4) begin
      #7 chk("clock out", pll_clk, dco);
      @(negedge core_clk);
    end
  endtask
  task automatic t_banks;
    for (int c = 1; c < 3; c++) begin
      pd = c[3:0];
      repeat (4) @(negedge core_clk);
      run(3'h3, 1'b0, 1'b0);
      chk("second row strobe", c == 1, row2_seen);
      stop();
    end
  endtask
  task automatic t_refuse;
    dma_en = 1'b0;
    for (int c = 0; c < 3; c++) begin
      @(negedge core_clk);
      cmd_region = (c == 0) ? 3'h0 : (c == 1) ? 3'h3 : 3'h7;
      cmd_dma = c == 1;
      go = 1'b1;
      repeat (20) @(negedge core_clk);
      chk("refused acks", 0, n_ack + n_wrong);
      chk("refused select", 0, sel_seen);
      stop();
    end
    dma_en = 1'b1;
  endtask
  // Row address first, then the column strobe with the acknowledge.
  task automatic t_dram_phase;
    int i;
    int n;
    @(negedge core_clk);
    cmd_region = 3'h3;
    cmd_burst = 1'b0;
    cmd_dma = 1'b0;
    go = 1'b1;
    n = 0;
    for (i = 0; i < 200 && done !== 1'b1; i++) begin
      @(negedge core_clk);
      if (dram_b === 1'b0) begin
        n++;
        if (n == 1) chk("row phase", 2'h3, {row_sel, cas_b});
        if (tack_b === 1'b0) begin
          chk("column phase", 2'h0, {row_sel, cas_b});
        end
      end
    end
    if (i == 200) begin
      chk("dram phase done", 1, done);
      close_out();
    end
    chk("dram select cycles", 3, n);
    stop();
  endtask
  task automatic t_pd;
    logic [7:0] ns_tab [4] = '{8'h64, 8'h50, 8'h46, 8'h3c};
    logic [3:0] org_tab [4] = '{4'h4, 4'h2, 4'h1, 4'h8};
    for (int c = 0; c < 16; c++) begin
      pd = c[3:0];
      repeat (4) @(negedge core_clk);
      chk("access time", ns_tab[c / 4], acc_ns);
      chk("organisation", org_tab[c % 4], units);
      chk("two banks", c % 2, two);
    end
  endtask
  task automatic t_refresh;
    int i;
    int n;
    for (i = 0; i < 100 && busy === 1'b1; i++) @(negedge core_clk);
    for (i = 0; i < 100 && busy !== 1'b1; i++) @(negedge core_clk);
    if (busy !== 1'b1) begin
      chk("refresh start", 1, busy);
      close_out();
    end
    n = 0;
    while (n < 10 && busy === 1'b1) begin
      chk("refresh strobes", 3'h0, {row1_b, row2_b, cas_b});
      chk("refresh selects", 4'hf, {dram_b, sram_b, bboot_b, boot_b});
      n++;
      @(negedge core_clk);
    end
    chk("refresh length", 3, n);
  endtask
  initial begin
    rst_b = 1'b0;
    osc = 1'b0;
    pll_locked = 1'b0;
    dma_en = 1'b1;
    go = 1'b0;
    cmd_region = 3'h0;
    cmd_burst = 1'b0;
    cmd_dma = 1'b0;
    pd = 4'h2;
    fails = 0;
    checks = 0;
    repeat (6) begin
      @(negedge core_clk);
      #7 chk("clock out", osc, dco);
    end
    @(negedge core_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge core_clk);
    t_lock();
    access(3'h1, 1'b0, 1'b0, 1, 3, 0, 4'h1);
    access(3'h1, 1'b1, 1'b0, 1, 3, 0, 4'h1);
    access(3'h4, 1'b0, 1'b0, 1, 3, 0, 4'h2);
    access(3'h2, 1'b0, 1'b0, 1, 2, 0, 4'h4);
    access(3'h2, 1'b1, 1'b0, 4, 2, 1, 4'h4);
    access(3'h2, 1'b0, 1'b1, 1, 2, 0, 4'h4);
    access(3'h3, 1'b0, 1'b0, 1, 2, 0, 4'h8);
    access(3'h3, 1'b1, 1'b0, 4, 2, 2, 4'h8);
    access(3'h3, 1'b1, 1'b1, 1, 2, 0, 4'h8);
    t_dram_phase();
    t_banks();
    t_refuse();
    t_pd();
    t_refresh();
    close_out();
  end
endmodule
`default_nettype wire
